// file: adc_group_ctrl_regs.sv
/*
  Configuration registers for converters 9-13 and serial lines 9-12,
  an APB slave, and the small datapath they steer.
  Assumes APB on clk, 32-bit data, registers one word each.
*/
`timescale 1ns/1ps
module adc_group_ctrl_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adc_grp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sixteen_input_mode,
  output logic [3:0] conv_pair_select,
  output logic per_line_pattern_enable,
  output logic [2:0] line11_pattern_code,
  output logic [2:0] line12_pattern_code,
  output logic [3:0] digital_sleep,
  output logic [3:0] analog_sleep,
  output logic [3:0] line_sleep,
  output logic highpass_enable_group3,
  output logic [3:0] highpass_corner_k,
  input wire logic [55:0] line_conv_data,
  input wire logic [3:0] line_pattern_active,
  input wire logic [55:0] line_pattern_word,
  output logic [55:0] line_word,
  input wire logic conv13_in_valid,
  input wire logic conv13_in_odd,
  input wire logic [13:0] conv13_in_sample,
  output logic conv13_out_valid,
  output logic [13:0] conv13_out_sample
);

  typedef struct packed {
    logic [15:0] insel_pattern;
    logic [15:0] sleep_invert;
    logic [15:0] gain_ofs;
    logic [15:0] global_go;
    logic [15:0] global_pat;
    logic [15:0] highpass;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [3:0] pair_sel;
    logic pat_en;
    logic [2:0] pat11;
    logic [2:0] pat12;
    logic [3:0] dig_sleep;
    logic [3:0] ana_sleep;
    logic [3:0] ln_sleep;
    logic hpf_en;
    logic [3:0] hpf_k;
  } regs_state_t;

  regs_state_t s_q;
  regs_state_t s_d;

  logic [5:0] idx;
  logic word_aligned;
  logic mapped;
  logic [15:0] rd_word;
  logic [15:0] wr_mask;
  logic commit_write;

  // Index decode; byte lanes 2 and 3 carry no register bits
  assign idx = paddr[7:2];
  assign word_aligned = (paddr[1:0] == 2'h0);
  assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign commit_write = psel && penable && s_q.ready && pwrite && mapped;

  always_comb begin
    mapped = word_aligned;
    rd_word = 16'h0000;
    case (idx)
      adc_grp_pkg::IDX_GLOBAL_GAIN_OFS: rd_word = s_q.global_go;
      adc_grp_pkg::IDX_GLOBAL_PATTERN: rd_word = s_q.global_pat;
      adc_grp_pkg::IDX_HIGHPASS_9_12: rd_word = s_q.highpass;
      adc_grp_pkg::IDX_INSEL_PATTERN: rd_word = s_q.insel_pattern;
      adc_grp_pkg::IDX_SLEEP_INVERT: rd_word = s_q.sleep_invert;
      adc_grp_pkg::IDX_GAIN_OFS_13_ODD: rd_word = s_q.gain_ofs;
      default: mapped = 1'b0;
    endcase
  end

  // Only the bits this slice owns are kept in the global registers
  localparam logic [15:0] GO_MASK = 16'h1100;
  localparam logic [15:0] PAT_MASK = 16'h0100;
  localparam logic [15:0] HPF_MASK = 16'h001F;

  always_comb begin
    s_d = s_q;
    // Wait state: pready rises one cycle into the access phase
    s_d.ready = psel && penable && !s_q.ready;
    s_d.err = 1'b0;
    if (psel && penable && !s_q.ready) begin
      // Refused reads return zero, never a neighbour's contents
      s_d.rdata = {16'h0000, (pwrite || !mapped) ? 16'h0000 : rd_word};
      s_d.err = !mapped;
    end
    if (commit_write) begin
      case (idx)
        adc_grp_pkg::IDX_GLOBAL_GAIN_OFS: begin
          s_d.global_go = (s_q.global_go & ~(wr_mask & GO_MASK)) |
            (pwdata[15:0] & wr_mask & GO_MASK);
        end
        adc_grp_pkg::IDX_GLOBAL_PATTERN: begin
          s_d.global_pat = (s_q.global_pat & ~(wr_mask & PAT_MASK)) |
            (pwdata[15:0] & wr_mask & PAT_MASK);
        end
        adc_grp_pkg::IDX_HIGHPASS_9_12: begin
          s_d.highpass = (s_q.highpass & ~(wr_mask & HPF_MASK)) |
            (pwdata[15:0] & wr_mask & HPF_MASK);
        end
        adc_grp_pkg::IDX_INSEL_PATTERN: begin
          s_d.insel_pattern = (s_q.insel_pattern & ~wr_mask) |
            (pwdata[15:0] & wr_mask);
        end
        adc_grp_pkg::IDX_SLEEP_INVERT: begin
          s_d.sleep_invert = (s_q.sleep_invert & ~wr_mask) |
            (pwdata[15:0] & wr_mask);
        end
        adc_grp_pkg::IDX_GAIN_OFS_13_ODD: begin
          s_d.gain_ofs = (s_q.gain_ofs & ~wr_mask) |
            (pwdata[15:0] & wr_mask);
        end
        default: begin
          s_d.err = 1'b0;
        end
      endcase
    end

    // Pair choice only meaningful in sixteen-input mode
    // Bit order as stored: pair_sel[3]=conv9 down to [0]=conv12
    s_d.pair_sel = sixteen_input_mode ?
      s_q.insel_pattern[adc_grp_pkg::POS_PAIR_SEL_LO +: 4] :
      4'h0;

    s_d.pat_en = s_q.global_pat[adc_grp_pkg::POS_PATTERN_EN];
    // Codes forced to zero when per-line choice is off
    s_d.pat11 = s_d.pat_en ?
      s_q.insel_pattern[adc_grp_pkg::POS_PAT11_LO +: 3] : 3'h0;
    s_d.pat12 = s_d.pat_en ?
      s_q.insel_pattern[adc_grp_pkg::POS_PAT12_LO +: 3] : 3'h0;

    // Bit 0 of each group is converter or line 9, as stored
    s_d.dig_sleep =
      s_q.sleep_invert[adc_grp_pkg::POS_DIG_SLEEP_LO +: 4];
    s_d.ln_sleep =
      s_q.sleep_invert[adc_grp_pkg::POS_LINE_SLEEP_LO +: 4];
    s_d.ana_sleep =
      s_q.sleep_invert[adc_grp_pkg::POS_ANA_SLEEP_LO +: 4];

    s_d.hpf_k = s_q.highpass[adc_grp_pkg::POS_HPF_K_LO +: 4];
    s_d.hpf_en = s_q.highpass[adc_grp_pkg::POS_HPF_EN] &&
      (s_d.hpf_k >= adc_grp_pkg::HPF_K_MIN) &&
      (s_d.hpf_k <= adc_grp_pkg::HPF_K_MAX);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.insel_pattern <= adc_grp_pkg::RST_INSEL_PATTERN;
      s_q.sleep_invert <= adc_grp_pkg::RST_SLEEP_INVERT;
      s_q.gain_ofs <= adc_grp_pkg::RST_GAIN_OFS_13_ODD;
      s_q.global_go <= adc_grp_pkg::RST_GLOBAL;
      s_q.global_pat <= adc_grp_pkg::RST_GLOBAL;
      s_q.highpass <= adc_grp_pkg::RST_HIGHPASS;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign conv_pair_select = s_q.pair_sel;
  assign per_line_pattern_enable = s_q.pat_en;
  assign line11_pattern_code = s_q.pat11;
  assign line12_pattern_code = s_q.pat12;
  assign digital_sleep = s_q.dig_sleep;
  assign analog_sleep = s_q.ana_sleep;
  assign line_sleep = s_q.ln_sleep;
  assign highpass_enable_group3 = s_q.hpf_en;
  assign highpass_corner_k = s_q.hpf_k;

  // Line i=0..3 is serial line 9..12; flip bit i is register bit i
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_line
      line_out_mux u_mux (
        .clk(clk),
        .srst(srst),
        .conv_data(line_conv_data[gi*14 +: 14]),
        .pattern_active(line_pattern_active[gi]),
        .pattern_word(line_pattern_word[gi*14 +: 14]),
        .flip(s_q.sleep_invert[adc_grp_pkg::POS_FLIP_LO + gi]),
        .line_sleep(s_q.ln_sleep[gi]),
        .line_word(line_word[gi*14 +: 14])
      );
    end
  endgenerate

  odd_gain_offset u_go (
    .clk(clk),
    .srst(srst),
    .in_valid(conv13_in_valid),
    .in_odd(conv13_in_odd),
    .in_sample(conv13_in_sample),
    .gain_en(s_q.global_go[adc_grp_pkg::POS_GAIN_EN]),
    .offset_en(s_q.global_go[adc_grp_pkg::POS_OFFSET_EN]),
    .gain_n(s_q.gain_ofs[adc_grp_pkg::POS_GAIN_LO +: 5]),
    .offset_val(s_q.gain_ofs[adc_grp_pkg::POS_OFFSET_LO +: 10]),
    .out_valid(conv13_out_valid),
    .out_sample(conv13_out_sample)
  );

endmodule : adc_group_ctrl_regs

// file: adc_group_ctrl_regs_assertions.sv
/*
  Port-level checker for adc_group_ctrl_regs.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module adc_group_ctrl_regs_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sixteen_input_mode,
  input wire logic [3:0] conv_pair_select,
  input wire logic per_line_pattern_enable,
  input wire logic [2:0] line11_pattern_code,
  input wire logic [2:0] line12_pattern_code,
  input wire logic [3:0] line_sleep,
  input wire logic highpass_enable_group3,
  input wire logic [3:0] highpass_corner_k,
  input wire logic [3:0] line_pattern_active,
  input wire logic [55:0] line_pattern_word,
  input wire logic [55:0] line_word,
  input wire logic conv13_in_valid,
  input wire logic conv13_in_odd,
  input wire logic [13:0] conv13_in_sample,
  input wire logic conv13_out_valid,
  input wire logic [13:0] conv13_out_sample
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  one_wait_a: assert property (psel && !penable ##1 psel && penable
    |-> !pready ##1 pready) else $error("pready not after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_read_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access not clean");
  pair_off_a: assert property (!sixteen_input_mode [*2]
    |-> conv_pair_select == 4'h0) else $error("pair select outside mode");
  pattern_off_a: assert property (!per_line_pattern_enable
    |-> line11_pattern_code == 3'h0 && line12_pattern_code == 3'h0)
    else $error("pattern code without enable");
  sleep_zero_a: assert property (line_sleep[0] [*2]
    |-> line_word[13:0] == 14'h0) else $error("sleeping line not zero");
  pattern_pass_a: assert property (line_pattern_active[1] &&
    !line_sleep[1] ##1 !line_sleep[1]
    |-> line_word[27:14] == $past(line_pattern_word[27:14]))
    else $error("pattern word altered");
  hpf_range_a: assert property (highpass_enable_group3
    |-> highpass_corner_k inside {[4'h2:4'hA]})
    else $error("highpass on with bad corner");
  c13_even_a: assert property (conv13_in_valid && !conv13_in_odd
    |-> ##2 conv13_out_valid && conv13_out_sample ==
    $past(conv13_in_sample, 2)) else $error("even sample altered");
endmodule : adc_group_ctrl_regs_chk

bind adc_group_ctrl_regs adc_group_ctrl_regs_chk i_chk (.clk, .srst,
  .psel, .penable, .prdata, .pready, .pslverr, .sixteen_input_mode,
  .conv_pair_select, .per_line_pattern_enable, .line11_pattern_code,
  .line12_pattern_code, .line_sleep, .highpass_enable_group3,
  .highpass_corner_k, .line_pattern_active, .line_pattern_word,
  .line_word, .conv13_in_valid, .conv13_in_odd, .conv13_in_sample,
  .conv13_out_valid, .conv13_out_sample);

// file: adc_grp_pkg.sv
/*
  Constants for the converter 9-13 configuration register slice:
  register indices, field positions, reset values and widths.
  Assumes a 32-bit APB master; byte address is four times the index.
*/
package adc_grp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SAMPLE_W = 14;
  localparam int unsigned NUM_LINES = 4;

  // Register indices; byte address = index * 4
  localparam logic [5:0] IDX_GLOBAL_GAIN_OFS = 6'h03;
  localparam logic [5:0] IDX_GLOBAL_PATTERN = 6'h04;
  localparam logic [5:0] IDX_HIGHPASS_9_12 = 6'h2D;
  localparam logic [5:0] IDX_INSEL_PATTERN = 6'h2F;
  localparam logic [5:0] IDX_SLEEP_INVERT = 6'h30;
  localparam logic [5:0] IDX_GAIN_OFS_13_ODD = 6'h31;

  localparam logic [15:0] RST_INSEL_PATTERN = 16'h0000;
  localparam logic [15:0] RST_SLEEP_INVERT = 16'h0000;
  localparam logic [15:0] RST_GAIN_OFS_13_ODD = 16'h0000;
  localparam logic [15:0] RST_GLOBAL = 16'h0000;
  localparam logic [15:0] RST_HIGHPASS = 16'h0000;

  // Global enables
  localparam int unsigned POS_GAIN_EN = 12;
  localparam int unsigned POS_OFFSET_EN = 8;
  localparam int unsigned POS_PATTERN_EN = 8;

  // Highpass control
  localparam int unsigned POS_HPF_EN = 0;
  localparam int unsigned POS_HPF_K_LO = 1;
  localparam logic [3:0] HPF_K_MIN = 4'h2;
  localparam logic [3:0] HPF_K_MAX = 4'hA;

  // Input select and pattern register
  localparam int unsigned POS_PAIR_SEL_LO = 8;
  localparam int unsigned POS_PAT11_LO = 5;
  localparam int unsigned POS_PAT12_LO = 2;

  // Sleep and invert register
  localparam int unsigned POS_DIG_SLEEP_LO = 12;
  localparam int unsigned POS_LINE_SLEEP_LO = 8;
  localparam int unsigned POS_ANA_SLEEP_LO = 4;
  localparam int unsigned POS_FLIP_LO = 0;

  // Gain and offset register
  localparam int unsigned POS_GAIN_LO = 11;
  localparam int unsigned POS_OFFSET_LO = 0;
  localparam int unsigned GAIN_W = 5;
  localparam int unsigned OFFSET_W = 10;
  localparam int unsigned GAIN_FRAC = 12;

endpackage : adc_grp_pkg

// file: line_out_mux.sv
/*
  One serial output line's word selection: test pattern, conversion
  data (optionally inverted) or idle zero when the line sleeps.
  Assumes pattern_word is produced on the same clock.
*/
`timescale 1ns/1ps
module line_out_mux (
  input wire logic clk,
  input wire logic srst,
  input wire logic [adc_grp_pkg::SAMPLE_W-1:0] conv_data,
  input wire logic pattern_active,
  input wire logic [adc_grp_pkg::SAMPLE_W-1:0] pattern_word,
  input wire logic flip,
  input wire logic line_sleep,
  output logic [adc_grp_pkg::SAMPLE_W-1:0] line_word
);

  typedef struct packed {
    logic [adc_grp_pkg::SAMPLE_W-1:0] word;
  } mux_state_t;

  mux_state_t s_q;
  mux_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (line_sleep) begin
      s_d.word = '0;
    end else if (pattern_active) begin
      s_d.word = pattern_word;
    end else if (flip) begin
      s_d.word = ~conv_data;
    end else begin
      s_d.word = conv_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_word = s_q.word;

endmodule : line_out_mux

// file: odd_gain_offset.sv
/*
  Offset subtraction and fine gain for converter 13 odd samples.
  Two-cycle pipeline; even samples and bypassed samples pass unchanged
  with the same latency. Assumes signed 14-bit samples.
*/
`timescale 1ns/1ps
module odd_gain_offset (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic in_odd,
  input wire logic [adc_grp_pkg::SAMPLE_W-1:0] in_sample,
  input wire logic gain_en,
  input wire logic offset_en,
  input wire logic [adc_grp_pkg::GAIN_W-1:0] gain_n,
  input wire logic [adc_grp_pkg::OFFSET_W-1:0] offset_val,
  output logic out_valid,
  output logic [adc_grp_pkg::SAMPLE_W-1:0] out_sample
);

  typedef struct packed {
    logic v1;
    logic g1;
    logic [4:0] n1;
    logic signed [15:0] x1;
    logic v2;
    logic [13:0] y2;
  } go_state_t;

  go_state_t s_q;
  go_state_t s_d;

  // Q2.12 factors for N x 0.2 dB; a table avoids a log unit
  function automatic logic [13:0] gain_factor(input logic [4:0] n);
    case (n)
      5'h00: gain_factor = 14'd4096;
      5'h01: gain_factor = 14'd4191;
      5'h02: gain_factor = 14'd4289;
      5'h03: gain_factor = 14'd4389;
      5'h04: gain_factor = 14'd4491;
      5'h05: gain_factor = 14'd4596;
      5'h06: gain_factor = 14'd4703;
      5'h07: gain_factor = 14'd4812;
      5'h08: gain_factor = 14'd4924;
      5'h09: gain_factor = 14'd5039;
      5'h0A: gain_factor = 14'd5157;
      5'h0B: gain_factor = 14'd5277;
      5'h0C: gain_factor = 14'd5400;
      5'h0D: gain_factor = 14'd5525;
      5'h0E: gain_factor = 14'd5654;
      5'h0F: gain_factor = 14'd5786;
      5'h10: gain_factor = 14'd5921;
      5'h11: gain_factor = 14'd6058;
      5'h12: gain_factor = 14'd6200;
      5'h13: gain_factor = 14'd6344;
      5'h14: gain_factor = 14'd6492;
      5'h15: gain_factor = 14'd6643;
      5'h16: gain_factor = 14'd6798;
      5'h17: gain_factor = 14'd6956;
      5'h18: gain_factor = 14'd7118;
      5'h19: gain_factor = 14'd7284;
      5'h1A: gain_factor = 14'd7453;
      5'h1B: gain_factor = 14'd7627;
      5'h1C: gain_factor = 14'd7805;
      5'h1D: gain_factor = 14'd7987;
      5'h1E: gain_factor = 14'd8173;
      default: gain_factor = 14'd8363;
    endcase
  endfunction : gain_factor

  logic signed [15:0] ofs_ext;
  logic signed [30:0] prod;
  logic signed [18:0] scaled;

  assign ofs_ext = 16'(signed'(offset_val));
  assign prod = s_q.x1 * $signed({1'b0, gain_factor(s_q.n1)});
  assign scaled = prod[30:12];

  always_comb begin
    s_d = s_q;
    s_d.v1 = in_valid;
    s_d.g1 = in_odd && gain_en;
    s_d.n1 = gain_n;
    s_d.x1 = 16'(signed'(in_sample));
    if (in_odd && offset_en) begin
      s_d.x1 = 16'(signed'(in_sample)) - ofs_ext;
    end
    s_d.v2 = s_q.v1;
    if (!s_q.g1) begin
      s_d.y2 = s_q.x1[13:0];
      if (s_q.x1 > 16'sd8191) s_d.y2 = 14'h1FFF;
      if (s_q.x1 < -16'sd8192) s_d.y2 = 14'h2000;
    end else if (scaled > 19'sd8191) begin
      s_d.y2 = 14'h1FFF; // Saturate rather than wrap
    end else if (scaled < -19'sd8192) begin
      s_d.y2 = 14'h2000;
    end else begin
      s_d.y2 = scaled[13:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_valid = s_q.v2;
  assign out_sample = s_q.y2;

endmodule : odd_gain_offset

// file: tb.sv
/*
  Self-checking bench for adc_group_ctrl_regs over APB.
  Assumes one wait state APB slave and the hand-over datapath latencies.
*/
`timescale 1ns/1ps
module tb;
  logic clk, srst, psel, penable, pwrite, mode, ple, hpe;
  logic c13v, c13o, c13ov, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cps, dsl, asl, lsl, hk, pact;
  logic [2:0] p11, p12;
  logic [55:0] cdat, pwrd, lw;
  logic [13:0] c13x, c13y;
  logic [15:0] rt[3] = '{16'hA5C3, 16'h5A0F, 16'h30F5};
  logic [3:0] pt[3] = '{4'hA, 4'h5, 4'h4};
  logic [7:0] at[3] = '{8'hBC, 8'hC0, 8'hC4};
  logic [3:0] kt[6] = '{4'h1, 4'h2, 4'hA, 4'hB, 4'h6, 4'h0};
  int error_cnt = 0;
  int n_compared = 0;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end

  adc_group_ctrl_regs i_adc_group_ctrl_regs (.clk, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb(4'h3), .prdata, .pready,
    .pslverr, .sixteen_input_mode(mode), .conv_pair_select(cps),
    .per_line_pattern_enable(ple), .line11_pattern_code(p11),
    .line12_pattern_code(p12), .digital_sleep(dsl), .analog_sleep(asl),
    .line_sleep(lsl), .highpass_enable_group3(hpe),
    .highpass_corner_k(hk), .line_conv_data(cdat),
    .line_pattern_active(pact), .line_pattern_word(pwrd),
    .line_word(lw), .conv13_in_valid(c13v), .conv13_in_odd(c13o),
    .conv13_in_sample(c13x), .conv13_out_valid(c13ov),
    .conv13_out_sample(c13y));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Starts on an edge so a release and a new setup never share a step
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) `CHK("pready", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    `CHK("read", e, rd[15:0])
    `CHK("no err", 1'b0, er)
  endtask : rdc

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  function automatic logic [55:0] lexp(input logic [15:0] r,
      input logic [3:0] pa);
    lexp = '0;
    for (int i = 0; i < 4; i++)
      if (!r[8+i])
        lexp[14*i +: 14] = pa[i] ? pwrd[14*i +: 14] :
          (r[i] ? ~cdat[14*i +: 14] : cdat[14*i +: 14]);
  endfunction : lexp

  function automatic logic [13:0] gexp(input int x, input logic g,
      input logic o, input logic [4:0] n, input logic [9:0] f);
    int y;
    y = o ? x - $signed(f) : x;
    if (g) y = (y * (n == 5'h1F ? 8363 : 4096)) >>> 12;
    if (y > 8191) y = 8191;
    if (y < -8192) y = -8192;
    gexp = y[13:0];
  endfunction : gexp

  task automatic c13(input logic odd, input int x, input logic [13:0] e);
    @(posedge clk);
    c13v <= 1'b1;
    c13o <= odd;
    c13x <= x[13:0];
    @(posedge clk);
    c13v <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("c13 valid", 1'b1, c13ov)
    `CHK("c13 sample", e, c13y)
  endtask : c13

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end

  initial begin : main
    {srst, psel, penable, pwrite, paddr, pwdata, mode} = '0;
    {pact, cdat, c13v, c13o, c13x} = '0;
    srst = 1'b1;
    cdat = 56'h0123456789ABCD;
    pwrd = 56'h3C3C5A5A0F0F96;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      rdc(at[i], 16'h0000);
      apb(1'b1, at[i], 16'hA55A ^ i[15:0]);
      rdc(at[i], 16'hA55A ^ i[15:0]);
    end
    // Unmapped read, then misaligned write that must be dropped
    apb(1'b0, 8'h40, 16'h0000);
    `CHK("err", 1'b1, er)
    `CHK("err data", 32'h0, rd)
    apb(1'b1, 8'hBD, 16'h1234);
    `CHK("err", 1'b1, er)
    apb(1'b0, 8'hBE, 16'h0000);
    `CHK("err", 1'b1, er)
    `CHK("err data", 32'h0, rd)
    rdc(8'hBC, 16'hA55A);
    @(posedge clk);
    mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'hBC, 16'h0100 << i);
      settle();
      `CHK("pair", 4'h1 << i, cps)
    end
    @(posedge clk);
    mode <= 1'b0;
    settle();
    `CHK("pair off", 4'h0, cps)
    apb(1'b1, 8'h10, 16'h0100);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'hBC, {8'h00, c[2:0], ~c[2:0], 2'b00});
      settle();
      `CHK("pat11", c[2:0], p11)
      `CHK("pat12", ~c[2:0], p12)
    end
    apb(1'b1, 8'h10, 16'h0000);
    settle();
    `CHK("pat off", 4'h0, {ple, p11})
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'hC0, rt[i]);
      @(posedge clk);
      pact <= pt[i];
      settle();
      `CHK("dig sleep", rt[i][15:12], dsl)
      `CHK("line sleep", rt[i][11:8], lsl)
      `CHK("ana sleep", rt[i][7:4], asl)
      `CHK("line word", lexp(rt[i], pt[i]), lw)
    end
    apb(1'b1, 8'hC4, 16'hF864);
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, 8'h0C, {3'h0, e[1], 3'h0, e[0], 8'h00});
      c13(1'b1, 1000, gexp(1000, e[1], e[0], 5'h1F, 10'd100));
      c13(1'b1, -1000, gexp(-1000, e[1], e[0], 5'h1F, 10'd100));
      c13(1'b0, 1000, 14'd1000);
    end
    c13(1'b1, 8000, 14'h1FFF);
    apb(1'b1, 8'hC4, 16'h03FF);
    c13(1'b1, 1000, gexp(1000, 1'b1, 1'b1, 5'h00, 10'h3FF));
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'hB4, {11'h0, kt[i], i != 4});
      settle();
      `CHK("hpf", i != 4 && kt[i] >= 4'h2 && kt[i] <= 4'hA, hpe)
      `CHK("hpf k", kt[i], hk)
    end
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    rdc(8'hC0, 16'h0000);
    end_sim();
  end
endmodule : tb
